/* File: sdp_packer.sv */
// Sample FIFO and frame payload packer for a 16-bit plus 8-bit sensor
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
// Plain synchronous FIFO; DEPTH is expected to be a power of two or
// any value above one, pointers wrap explicitly.
module sdp_fifo
#(
   parameter int W = 8,
   parameter int DEPTH = 8
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   // All control state of the FIFO
   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [CW-1:0] count;
   } sdp_fifo_state_t;

   sdp_fifo_state_t st_r;   // Registered pointers and fill count
   sdp_fifo_state_t st_nxt; // Next value
   logic [W-1:0] mem [DEPTH]; // Storage, no reset needed
   logic push;              // Word accepted this cycle
   logic pop;               // Word handed out this cycle

   // Advance a pointer with wrap at the last slot
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction

   // Honest flags straight from the count
   assign in_ready = (st_r.count != FULL_CNT);
   assign out_valid = (st_r.count != '0);
   assign out_data = mem[st_r.rptr];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   // Next pointers and count
   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.wptr = ptr_inc(st_r.wptr);
      end
      if (pop)
      begin
         st_nxt.rptr = ptr_inc(st_r.rptr);
      end
      // Simultaneous push and pop leaves the count alone
      if (push && !pop)
      begin
         st_nxt.count = st_r.count + 1'b1;
      end
      else if (pop && !push)
      begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Storage write; kept out of reset to stay a plain memory
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem[st_r.wptr] <= in_data;
      end
   end

endmodule

// ------------------------------------------------------------------
// Frame payload packer
// ------------------------------------------------------------------
// Functional notes
// - Exactly six data nibbles per frame.
// - Channel 1 into nibbles one to four, MSB first.
// - Channel 2 low nibble fifth, high sixth.
// - Status bit 0 flags channel 1 error.
// - Status bit 1 flags channel 2 error.
// - Unused channel 2 sends nibbles five, six zero.
// - Status bits 3 and 2 carry serial channel.
module sdp_packer
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic smp_valid,
   output logic smp_ready,
   input wire sdp_pkg::sdp_sample_t smp,
   input wire logic [1:0] serial_bits,
   output logic frm_valid,
   input wire logic frm_ready,
   output sdp_pkg::sdp_frame_t frm
);

   localparam int SMP_W = $bits(sdp_pkg::sdp_sample_t);

   // All control state of the packer
   typedef struct packed {
      sdp_pkg::sdp_state_t state;
      sdp_pkg::sdp_frame_t frame;
   } sdp_pk_state_t;

   sdp_pk_state_t st_r;          // Registered state and held frame
   sdp_pk_state_t st_nxt;        // Next value
   logic [SMP_W-1:0] fifo_raw;   // FIFO head as a vector
   sdp_pkg::sdp_sample_t fifo_data; // FIFO head as a sample set
   logic fifo_valid;             // A sample set waits in the FIFO
   logic fifo_pop;               // Packer takes the head this cycle
   logic capture;                // Frame start: sample set is latched

   // Build one payload from a sample set and the serial bits
   function automatic sdp_pkg::sdp_frame_t pack_frame(
      input sdp_pkg::sdp_sample_t s,
      input logic [1:0] ser
   );
      sdp_pkg::sdp_frame_t f;
      f = sdp_pkg::FRAME_RST;
      // Serial channel stays apart from the error flags
      f.status[sdp_pkg::ST_SER_HI] = ser[1];
      f.status[sdp_pkg::ST_SER_LO] = ser[0];
      f.status[sdp_pkg::ST_CH1_ERR] = s.ch1_err;
      f.status[sdp_pkg::ST_CH2_ERR] = s.ch2_err;
      // Channel 1 fills four slots, most significant nibble first
      for (int k = 0; k < sdp_pkg::NUM_CH1_NIB; k++)
      begin
         f.data[k] = s.ch1[sdp_pkg::CH1_W - sdp_pkg::NIB_W*(k+1)
                           +: sdp_pkg::NIB_W];
      end
      // Channel 2 nibbles go out in reversed order
      if (s.ch2_used)
      begin
         f.data[sdp_pkg::NIB_CH2_LOW] = s.ch2[3:0];
         f.data[sdp_pkg::NIB_CH2_HIGH] = s.ch2[7:4];
      end
      else
      begin
         f.data[sdp_pkg::NIB_CH2_LOW] = sdp_pkg::NIB_ZERO;
         f.data[sdp_pkg::NIB_CH2_HIGH] = sdp_pkg::NIB_ZERO;
      end
      pack_frame = f;
   endfunction

   // Sample sets queue here so the sensor paths need not wait on a
   // frame boundary; when it fills, smp_ready drops.
   sdp_fifo
   #(
      .W(SMP_W),
      .DEPTH(sdp_pkg::FIFO_DEPTH)
   )
   u_fifo
   (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .in_valid(smp_valid),
      .in_ready(smp_ready),
      .in_data(smp),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_raw)
   );

   assign fifo_data = sdp_pkg::sdp_sample_t'(fifo_raw);

   // Only an idle packer takes a new set; a frame under way is never
   // overwritten, so the transmitter's stall backs up into the FIFO.
   assign fifo_pop = (st_r.state == sdp_pkg::PK_IDLE);
   assign capture = ce && fifo_pop && fifo_valid;
   assign frm_valid = (st_r.state == sdp_pkg::PK_HOLD);
   assign frm = st_r.frame;

   // Next state
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r.state)
         // Waiting for a sample set
         sdp_pkg::PK_IDLE:
         begin
            if (capture)
            begin
               // Whole set latched in one edge
               st_nxt.frame = pack_frame(fifo_data, serial_bits);
               st_nxt.state = sdp_pkg::PK_HOLD;
            end
         end
         // Frame offered until the transmitter takes it
         sdp_pkg::PK_HOLD:
         begin
            if (ce && frm_ready)
            begin
               st_nxt.state = sdp_pkg::PK_IDLE;
            end
         end
         // Illegal code: recover to idle
         default:
         begin
            st_nxt.state = sdp_pkg::PK_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r.state <= sdp_pkg::PK_IDLE;
         st_r.frame <= sdp_pkg::FRAME_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_ch1_order: assert property (
      capture |=> {frm.data[0], frm.data[1], frm.data[2], frm.data[3]}
                  == $past(fifo_data.ch1))
      else $error("channel 1 nibbles out of order");

   a_ch2_swap: assert property (
      capture && fifo_data.ch2_used
      |=> {frm.data[5], frm.data[4]} == $past(fifo_data.ch2))
      else $error("channel 2 nibbles not reversed");

   a_ch2_unused: assert property (
      capture && !fifo_data.ch2_used
      |=> frm.data[5] == 4'h0 && frm.data[4] == 4'h0)
      else $error("unused channel 2 nibbles not zero");

   a_ch1_flag: assert property (
      capture |=> frm.status[0] == $past(fifo_data.ch1_err))
      else $error("channel 1 error flag wrong");

   a_ch2_flag: assert property (
      capture |=> frm.status[1] == $past(fifo_data.ch2_err))
      else $error("channel 2 error flag wrong");

   a_serial_bits: assert property (
      capture |=> frm.status[3:2] == $past(serial_bits))
      else $error("serial bits misplaced");

   a_frame_hold: assert property (
      frm_valid && !(ce && frm_ready) |=> frm_valid && $stable(frm))
      else $error("offered frame changed before taken");

   a_frame_release: assert property (
      frm_valid && ce && frm_ready |=> !frm_valid ##1 1'b1)
      else $error("frame not released after handshake");

   a_enable_freeze: assert property (
      !ce |=> $stable(st_r))
      else $error("state moved with clock enable low");

   c_capture: cover property (capture ##1 frm_valid);
   c_ch2_unused: cover property (capture && !fifo_data.ch2_used);
   c_stall: cover property ((frm_valid && !frm_ready) [*3]);
   c_fifo_full: cover property (smp_valid && !smp_ready);

endmodule
`default_nettype wire

/* File: sdp_pkg.sv */
// Shared constants and types for the dual-channel frame payload packer
`default_nettype none
package sdp_pkg;

   // --------------------------------------------------------------
   // Widths and counts
   // --------------------------------------------------------------
   localparam int CH1_W = 16;           // Fast channel 1 value width
   localparam int CH2_W = 8;            // Fast channel 2 value width
   localparam int NIB_W = 4;            // Bits per nibble
   localparam int NUM_DATA_NIB = 6;     // Data nibbles per frame
   localparam int NUM_CH1_NIB = 4;      // Data nibbles taken by channel 1
   localparam int FIFO_DEPTH = 8;       // Sample sets buffered ahead

   // --------------------------------------------------------------
   // Status and communication nibble bit positions
   // --------------------------------------------------------------
   localparam int ST_CH1_ERR = 0;       // Channel 1 error flag
   localparam int ST_CH2_ERR = 1;       // Channel 2 error flag
   localparam int ST_SER_LO = 2;        // Serial data channel, low bit
   localparam int ST_SER_HI = 3;        // Serial data channel, high bit

   // --------------------------------------------------------------
   // Data nibble slots (index 0 is data nibble one)
   // --------------------------------------------------------------
   localparam int NIB_TOP = 0;          // top_nibble of channel 1
   localparam int NIB_UPPER_MID = 1;    // upper_middle_nibble of channel 1
   localparam int NIB_LOWER_MID = 2;    // lower_middle_nibble of channel 1
   localparam int NIB_BOTTOM = 3;       // bottom_nibble of channel 1
   localparam int NIB_CH2_LOW = 4;      // Channel 2 bits 3..0
   localparam int NIB_CH2_HIGH = 5;     // Channel 2 bits 7..4
   localparam logic [3:0] NIB_ZERO = 4'h0;

   // --------------------------------------------------------------
   // Carriers
   // --------------------------------------------------------------
   // One measurement set from the sensor paths
   typedef struct packed {
      logic [CH1_W-1:0] ch1;
      logic [CH2_W-1:0] ch2;
      logic ch1_err;
      logic ch2_err;
      logic ch2_used;
   } sdp_sample_t;

   // One frame payload: status nibble plus six data nibbles
   typedef struct packed {
      logic [NIB_W-1:0] status;
      logic [NUM_DATA_NIB-1:0][NIB_W-1:0] data;
   } sdp_frame_t;

   // Packer states, one-hot
   typedef enum logic [1:0] {
      PK_IDLE = 2'b01,
      PK_HOLD = 2'b10
   } sdp_state_t;

   localparam sdp_frame_t FRAME_RST = '0;

endpackage
`default_nettype wire

/* File: sdp_sink_model.sv */
// Frame transmitter stand-in that takes payloads with random stalls
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Frame sink model
// ------------------------------------------------------------------
// Only frm_ready is driven here; the bench checks each payload taken.
module sdp_sink_model
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic stall,
   input wire logic frm_valid,
   output logic frm_ready,
   input wire sdp_pkg::sdp_frame_t frm
);
   // Ready moves just after the falling edge, so it is settled at the
   // rising edge; a slow nibble line is mimicked by random refusals.
   always @(negedge mclk or negedge rstn)
   begin
      if (!rstn)
         frm_ready <= 1'b0;
      else if (stall)
         frm_ready <= 1'b0;
      else
         frm_ready <= ($urandom_range(0, 3) != 0);
   end
endmodule
`default_nettype wire

/* File: sent_dual_channel_16_8_packer_bench.sv */
// Self-checking bench for the dual-channel frame payload packer
`timescale 1ns/100ps
`default_nettype none

module sent_dual_channel_16_8_packer_bench;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic mclk, rstn, ce, ce_rand, stall;
   logic smp_valid, smp_ready, frm_valid, frm_ready;
   logic [1:0] serial_bits;
   sdp_pkg::sdp_sample_t smp;
   sdp_pkg::sdp_frame_t frm;
   sdp_pkg::sdp_frame_t want; // Oldest payload owed, being compared
   sdp_pkg::sdp_frame_t exp_q[$]; // Payloads still owed, in order
   sdp_pkg::sdp_sample_t corner[4]; // Hand-picked edge values
   int bad_count, n_compared;

   sdp_packer DUT (.mclk(mclk), .rstn(rstn), .ce(ce),
      .smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp),
      .serial_bits(serial_bits), .frm_valid(frm_valid),
      .frm_ready(frm_ready), .frm(frm));
   sdp_sink_model SINK (.mclk(mclk), .rstn(rstn), .stall(stall),
      .frm_valid(frm_valid), .frm_ready(frm_ready), .frm(frm));

   // ---------------------------------------------------------------
   // Expectations and comparisons
   // ---------------------------------------------------------------
   // Payload worked out from one sample set and the serial bits
   function automatic sdp_pkg::sdp_frame_t pack(sdp_pkg::sdp_sample_t s,
      logic [1:0] ser);
      sdp_pkg::sdp_frame_t f;
      f.status = {ser, s.ch2_err, s.ch1_err};
      f.data[0] = s.ch1[15:12];
      f.data[1] = s.ch1[11:8];
      f.data[2] = s.ch1[7:4];
      f.data[3] = s.ch1[3:0];
      f.data[4] = s.ch2_used ? s.ch2[3:0] : 4'h0;
      f.data[5] = s.ch2_used ? s.ch2[7:4] : 4'h0;
      return f;
   endfunction

   task automatic chk_frm(sdp_pkg::sdp_frame_t got, sdp_pkg::sdp_frame_t e);
      n_compared++;
      if (got !== e)
      begin
         bad_count++;
         $display("BAD %0t frame got %h want %h", $time, got, e);
      end
   endtask

   task automatic chk_bit(logic got, logic e, string what);
      n_compared++;
      if (got !== e)
      begin
         bad_count++;
         $display("BAD %0t %s got %b want %b", $time, what, got, e);
      end
   endtask

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Drivers
   // ---------------------------------------------------------------
   // Offer one sample at a falling edge and hold it until taken
   task automatic push(sdp_pkg::sdp_sample_t s);
      int n;
      n = 0;
      smp <= s;
      smp_valid <= 1'b1;
      // Enable moves at this same falling edge; judge the take only
      // once it has settled, as the next rising edge will see it
      #1;
      while (!(smp_ready === 1'b1 && ce === 1'b1) && n < 500)
      begin
         @(negedge mclk);
         #1;
         n++;
      end
      exp_q.push_back(pack(s, serial_bits));
      @(negedge mclk);
   endtask

   // Wait until every offered payload has been taken
   task automatic drain;
      int n;
      n = 0;
      smp_valid <= 1'b0;
      while (exp_q.size() != 0 && n < 3000)
      begin
         @(negedge mclk);
         n++;
      end
      chk_bit(exp_q.size() == 0, 1'b1, "drained");
   endtask

   // Random clock-enable gaps freeze the whole block
   always @(negedge mclk)
      ce <= ce_rand ? ($urandom_range(0, 7) != 0) : 1'b1;

   // Every payload handed over must match the oldest one owed
   always @(posedge mclk)
   begin
      if (rstn === 1'b1 && ce === 1'b1 && frm_valid === 1'b1 &&
         frm_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk_bit(1'b1, 1'b0, "unexpected frame");
         else
         begin
            want = exp_q.pop_front();
            chk_frm(frm, want);
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Whole run is roughly a thousand cycles; this is far beyond it
   initial
   begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      test_done();
   end

   initial
   begin
      sdp_pkg::sdp_sample_t s;
      bad_count = 0;
      n_compared = 0;
      rstn = 1'b0;
      ce = 1'b1;
      ce_rand = 1'b0;
      stall = 1'b0;
      smp_valid = 1'b0;
      smp = '0;
      serial_bits = 2'h0;
      void'($urandom(18));
      repeat (8) @(negedge mclk);
      chk_bit(frm_valid, 1'b0, "reset valid");
      chk_bit(smp_ready, 1'b1, "reset ready");
      chk_frm(frm, sdp_pkg::FRAME_RST);
      rstn = 1'b1;
      // Corner values: extremes, reversed channel 2, unused channel 2
      corner[0] = {16'hffff, 8'h00, 1'b1, 1'b0, 1'b1};
      corner[1] = {16'h0000, 8'hff, 1'b0, 1'b1, 1'b1};
      corner[2] = {16'h1234, 8'hab, 1'b1, 1'b1, 1'b1};
      corner[3] = {16'h8001, 8'hff, 1'b0, 1'b0, 1'b0};
      // Serial bits are taken at capture, not at push, so they only
      // change while nothing is in flight
      for (int i = 0; i < 4; i++)
      begin
         serial_bits = i[1:0];
         push(corner[i]);
         drain();
      end
      // Sink stalled: one set held by the packer, eight fill the FIFO
      stall = 1'b1;
      for (int i = 0; i < 9; i++)
         push(sdp_pkg::sdp_sample_t'($urandom));
      smp_valid <= 1'b0;
      @(negedge mclk);
      chk_bit(smp_ready, 1'b0, "full refuses");
      chk_bit(frm_valid, 1'b1, "held frame");
      stall = 1'b0;
      drain();
      // Random bursts with enable gaps and random stalls
      ce_rand = 1'b1;
      for (int b = 0; b < 40; b++)
      begin
         serial_bits = 2'($urandom);
         repeat ($urandom_range(1, 12))
         begin
            s = sdp_pkg::sdp_sample_t'($urandom);
            push(s);
         end
         drain();
      end
      test_done();
   end
endmodule
`default_nettype wire
